/* core/sswcd_pkg.sv */
// constants and types of the slave write command decoder
package sswcd_pkg;

  // ----------------------------------------------------------------
  // frame layout, in bit positions counted from the start condition
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned POS_W = 6;
  localparam logic [5:0] BIT_START = 6'h01;
  localparam logic [5:0] BIT_RW = 6'h09;
  localparam logic [5:0] BIT_ACK_ADDR = 6'h0A;
  localparam logic [5:0] BIT_CMD_LAST = 6'h12;
  localparam logic [5:0] BIT_ACK_CMD = 6'h13;
  localparam logic [5:0] BIT_DATA_LAST = 6'h1B;
  localparam logic [5:0] BIT_ACK_DATA = 6'h1C;

  // ----------------------------------------------------------------
  // write register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SLAVE_COMMAND = 8'h00;
  localparam logic [7:0] REG_DATA_MESSAGE_0 = 8'h04;
  localparam logic [7:0] REG_DATA_MESSAGE_1 = 8'h05;

  // ----------------------------------------------------------------
  // command register values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WAKE_OR_SMI = 8'h01;
  localparam logic [7:0] CMD_POWERDOWN = 8'h02;
  localparam logic [7:0] CMD_RESET_NO_CYCLE = 8'h03;
  localparam logic [7:0] CMD_RESET_WITH_CYCLE = 8'h04;
  localparam logic [7:0] CMD_DISABLE_MESSAGES = 8'h05;
  localparam logic [7:0] CMD_WATCHDOG_RELOAD = 8'h06;
  localparam logic [7:0] CMD_LINK_SLAVE_SMI = 8'h08;

  // ----------------------------------------------------------------
  // reset control register images
  // ----------------------------------------------------------------
  // bits 2:1 set, bit 3 clear
  localparam logic [7:0] RSTC_NO_CYCLE = 8'h06;
  // bits 3:1 set
  localparam logic [7:0] RSTC_WITH_CYCLE = 8'h0E;
  localparam logic [7:0] RSTC_IDLE = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic inS0;
    logic sleepEnginePowered;
    logic sleepEnginePowerGated;
    logic sleepEngineOff;
    logic gracefulSleepEntry;
  } sswcd_sys_state_t;

  typedef struct packed {
    logic smbusWakeStatus;
    logic powerButtonOverrideStatus;
    logic linkSlaveSmiStatus;
  } sswcd_status_t;

  typedef struct packed {
    logic wakeSystem;
    logic systemMgmtInterrupt;
    logic powerdown;
    logic watchdogReload;
    logic resetCtrlWrite;
  } sswcd_action_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA,
    ST_WAIT_STOP
  } sswcd_state_t;

endpackage

/* core/sswcd_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module sswcd_sync #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  if (STAGES < 2) begin : gBadStages
    $error("sswcd_sync needs at least two stages");
  end

  for (genvar b = 0; b < WIDTH; b++) begin : gBit
    logic [STAGES-1:0] chain_ff;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        chain_ff <= '1;
      end else if (ce) begin
        chain_ff <= {chain_ff[STAGES-2:0], asyncIn[b]};
      end
    end
    assign syncOut[b] = chain_ff[STAGES-1];
  end

endmodule
`default_nettype wire

/* core/sswcd_top.sv */
// slave byte write receiver and command decoder
//
// Overview of operation
// R1: command byte, bits 11 to 18, selects register
// R2: bits 20 to 27 carry the written value
// R3: index 0 command, 4 and 5 message bytes
// R4: new message byte always replaces old one
// R5: master waits for processor read before rewriting
// R6: write and read race left unprotected
// R7: command 1 wakes when asleep, else interrupt
// R8: command 1 always sets wake status bit
// R9: command 2 sets override status, powers down
// R10: command 3 writes reset image without cycling
// R11: command 3 dropped unless in S0
// R12: command 4 writes reset image with cycling
// R13: command 4 honoured with engine powered or gated
// R14: engine off: command 4 only after graceful sleep
// R15: command 5 stops heartbeat and event messages
// R16: only resume-well reset re-enables messages
// R17: command 6 reloads the watchdog
// R18: commands 0, 7, reserved indices: no action
// R19: command 8 sets link status only in S0
`timescale 1ns/1ps
`default_nettype none
module sswcd_top
  import sswcd_pkg::*;
#(
  parameter int unsigned DATA_W = BYTE_W,
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic resumeWellReset_n,
  input wire logic smbClkIn,
  input wire logic smbDataIn,
  output logic smbDataOut,
  output logic smbDataOe,
  input wire sswcd_sys_state_t sysState,
  input wire sswcd_status_t statusClear,
  output sswcd_status_t status,
  output sswcd_action_t action,
  output logic [7:0] resetCtrlData,
  output logic [7:0] slaveCommand,
  output logic [7:0] dataMessage0,
  output logic [7:0] dataMessage1,
  output logic heartbeatDisabled
);

  if (DATA_W != BYTE_W) begin : gBadWidth
    $error("sswcd_top only serves eight-bit bytes");
  end

  // ----------------------------------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------------------------------
  logic [1:0] pinSync;
  logic sclSync;
  logic sdaSync;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  sswcd_sync #(
    .WIDTH(2),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .asyncIn({smbClkIn, smbDataIn}),
    .syncOut(pinSync)
  );

  assign sclSync = pinSync[1];
  assign sdaSync = pinSync[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else if (ce) begin
      sclPrev_ff <= sclSync;
      sdaPrev_ff <= sdaSync;
    end
  end

  assign sclRise = sclSync & ~sclPrev_ff;
  assign sclFall = ~sclSync & sclPrev_ff;
  // data moving while the clock stays high frames a transfer
  assign startSeen = sclSync & sclPrev_ff & sdaPrev_ff & ~sdaSync;
  assign stopSeen = sclSync & sclPrev_ff & ~sdaPrev_ff & sdaSync;

  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  sswcd_state_t state_ff;
  logic [POS_W-1:0] bitPos_ff;
  logic [POS_W-1:0] nxt_bitPos;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] regIndex_ff;
  logic [7:0] dataByte_ff;
  logic writeStrobe_ff;
  logic byteTaken_ff;

  assign nxt_bitPos = bitPos_ff + POS_W'(1);
  assign nxt_shift = {shift_ff[6:0], sdaSync};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitPos_ff <= '0;
    end else if (ce) begin
      if (startSeen) begin
        bitPos_ff <= BIT_START;
      end else if (sclRise && state_ff != ST_IDLE && bitPos_ff != '1) begin
        bitPos_ff <= nxt_bitPos;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= BYTE_RESET;
    end else if (ce) begin
      if (sclRise) begin
        shift_ff <= nxt_shift;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else if (ce) begin
      if (startSeen) begin
        state_ff <= ST_ADDR;
      end else if (stopSeen) begin
        state_ff <= ST_IDLE;
      end else if (sclRise) begin
        unique case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_IDLE;
          end
          ST_ADDR: begin
            if (nxt_bitPos == BIT_RW) begin
              // read cycles are not served here
              state_ff <= sdaSync ? ST_WAIT_STOP : ST_CMD;
            end
          end
          ST_CMD: begin
            if (nxt_bitPos == BIT_CMD_LAST) begin
              state_ff <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (nxt_bitPos == BIT_DATA_LAST) begin
              state_ff <= ST_WAIT_STOP;
            end
          end
          ST_WAIT_STOP: begin
            state_ff <= ST_WAIT_STOP;
          end
        endcase
      end
    end
  end

  // command byte selects the target register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regIndex_ff <= BYTE_RESET;
    end else if (ce) begin
      if (sclRise && state_ff == ST_CMD && nxt_bitPos == BIT_CMD_LAST) begin
        regIndex_ff <= nxt_shift; // R1
      end
    end
  end

  // data byte, committed with a one-cycle strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataByte_ff <= BYTE_RESET;
      writeStrobe_ff <= 1'b0;
    end else if (ce) begin
      writeStrobe_ff <= 1'b0;
      if (sclRise && state_ff == ST_DATA && nxt_bitPos == BIT_DATA_LAST) begin
        dataByte_ff <= nxt_shift; // R2
        writeStrobe_ff <= 1'b1;
      end
    end
  end

  // remembers that the data byte of this frame was taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byteTaken_ff <= 1'b0;
    end else if (ce) begin
      if (startSeen || stopSeen) begin
        byteTaken_ff <= 1'b0;
      end else if (writeStrobe_ff) begin
        byteTaken_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // acknowledge drive
  // ----------------------------------------------------------------
  logic ackDue;
  logic ackOe_ff;
  logic dataOut_ff;

  // every write byte is acknowledged, reserved targets included
  assign ackDue = (state_ff == ST_CMD && bitPos_ff == BIT_RW) ||
                  (state_ff == ST_DATA && bitPos_ff == BIT_CMD_LAST) ||
                  (state_ff == ST_WAIT_STOP && bitPos_ff == BIT_DATA_LAST &&
                   (byteTaken_ff || writeStrobe_ff)); // R18

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackOe_ff <= 1'b0;
      dataOut_ff <= 1'b0;
    end else if (ce) begin
      dataOut_ff <= 1'b0;
      if (startSeen || stopSeen) begin
        ackOe_ff <= 1'b0;
      end else if (sclFall) begin
        // held from the low phase before the ack bit to the one after
        ackOe_ff <= ackDue;
      end
    end
  end

  // ----------------------------------------------------------------
  // write register targets
  // ----------------------------------------------------------------
  logic cmdWrite;
  logic [7:0] slaveCommand_ff;
  logic [7:0] dataMessage0_ff;
  logic [7:0] dataMessage1_ff;

  assign cmdWrite = writeStrobe_ff && regIndex_ff == REG_SLAVE_COMMAND; // R3

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slaveCommand_ff <= BYTE_RESET;
    end else if (ce) begin
      if (cmdWrite) begin
        slaveCommand_ff <= dataByte_ff;
      end
    end
  end

  // no guard against a processor read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataMessage0_ff <= BYTE_RESET;
      dataMessage1_ff <= BYTE_RESET;
    end else if (ce) begin
      if (writeStrobe_ff && regIndex_ff == REG_DATA_MESSAGE_0) begin // R3
        dataMessage0_ff <= dataByte_ff; // R4 R6
      end
      if (writeStrobe_ff && regIndex_ff == REG_DATA_MESSAGE_1) begin // R3
        dataMessage1_ff <= dataByte_ff; // R4 R6
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic cmdWake;
  logic cmdPowerdown;
  logic cmdResetNoCycle;
  logic cmdResetWithCycle;
  logic cmdDisable;
  logic cmdReload;
  logic cmdLinkSmi;
  logic cycleResetAllowed;

  assign cmdWake = cmdWrite && dataByte_ff == CMD_WAKE_OR_SMI;
  assign cmdPowerdown = cmdWrite && dataByte_ff == CMD_POWERDOWN;
  assign cmdResetNoCycle = cmdWrite && dataByte_ff == CMD_RESET_NO_CYCLE;
  assign cmdResetWithCycle = cmdWrite && dataByte_ff == CMD_RESET_WITH_CYCLE;
  assign cmdDisable = cmdWrite && dataByte_ff == CMD_DISABLE_MESSAGES;
  assign cmdReload = cmdWrite && dataByte_ff == CMD_WATCHDOG_RELOAD;
  assign cmdLinkSmi = cmdWrite && dataByte_ff == CMD_LINK_SLAVE_SMI;

  assign cycleResetAllowed = sysState.inS0 ||
                             sysState.sleepEnginePowered || // R13
                             sysState.sleepEnginePowerGated || // R13
                             (sysState.sleepEngineOff && sysState.gracefulSleepEntry); // R14

  // ----------------------------------------------------------------
  // system action pulses
  // ----------------------------------------------------------------
  sswcd_action_t action_ff;
  logic [7:0] resetCtrlData_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      action_ff <= '0;
    end else if (ce) begin
      action_ff.wakeSystem <= cmdWake && !sysState.inS0; // R7
      action_ff.systemMgmtInterrupt <= cmdWake && sysState.inS0; // R7
      action_ff.powerdown <= cmdPowerdown; // R9
      action_ff.watchdogReload <= cmdReload; // R17
      action_ff.resetCtrlWrite <= (cmdResetNoCycle && sysState.inS0) || // R11
                                  (cmdResetWithCycle && cycleResetAllowed); // R12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCtrlData_ff <= RSTC_IDLE;
    end else if (ce) begin
      if (cmdResetNoCycle && sysState.inS0) begin
        resetCtrlData_ff <= RSTC_NO_CYCLE; // R10 R11
      end else if (cmdResetWithCycle && cycleResetAllowed) begin
        resetCtrlData_ff <= RSTC_WITH_CYCLE; // R12
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky status bits, a set beats a clear in the same cycle
  // ----------------------------------------------------------------
  sswcd_status_t status_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff.smbusWakeStatus <= 1'b0;
    end else if (ce) begin
      if (cmdWake) begin
        status_ff.smbusWakeStatus <= 1'b1; // R8
      end else if (statusClear.smbusWakeStatus) begin
        status_ff.smbusWakeStatus <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff.powerButtonOverrideStatus <= 1'b0;
    end else if (ce) begin
      if (cmdPowerdown) begin
        status_ff.powerButtonOverrideStatus <= 1'b1; // R9
      end else if (statusClear.powerButtonOverrideStatus) begin
        status_ff.powerButtonOverrideStatus <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff.linkSlaveSmiStatus <= 1'b0;
    end else if (ce) begin
      if (cmdLinkSmi && sysState.inS0) begin
        status_ff.linkSlaveSmiStatus <= 1'b1; // R19
      end else if (statusClear.linkSlaveSmiStatus) begin
        status_ff.linkSlaveSmiStatus <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // message disable, cleared by the resume-well reset alone
  // ----------------------------------------------------------------
  logic heartbeatDisabled_ff;

  always_ff @(posedge clk or negedge resumeWellReset_n) begin
    if (!resumeWellReset_n) begin
      heartbeatDisabled_ff <= 1'b0; // R16
    end else if (ce) begin
      if (cmdDisable) begin
        heartbeatDisabled_ff <= 1'b1; // R15
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign smbDataOut = dataOut_ff;
  assign smbDataOe = ackOe_ff;
  assign status = status_ff;
  assign action = action_ff;
  assign resetCtrlData = resetCtrlData_ff;
  assign slaveCommand = slaveCommand_ff;
  assign dataMessage0 = dataMessage0_ff;
  assign dataMessage1 = dataMessage1_ff;
  assign heartbeatDisabled = heartbeatDisabled_ff;

endmodule
`default_nettype wire

/* verif/smbus_slave_write_command_decoder_test.sv */
// testbench of the slave write command decoder
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_write_command_decoder_test
  import sswcd_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, resumeWellReset_n = 1'b0, clrAct = 1'b0;
  logic sclOut, sdaOut, sdaLine, smbDataOut, smbDataOe, heartbeatDisabled;
  sswcd_sys_state_t sysState = 5'h10;
  sswcd_status_t statusClear = '0, status;
  sswcd_action_t action, seenAct = '0;
  logic [7:0] resetCtrlData, slaveCommand, dataMessage0, dataMessage1;
  logic [4:0] st [5] = '{5'h10, 5'h08, 5'h04, 5'h03, 5'h02};
  logic ok [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int errors = 0, n_checks = 0, cyc = 0;
  // pull-up on the data wire
  assign sdaLine = sdaOut & (smbDataOe ? smbDataOut : 1'b1);
  sswcd_top sswcd_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .resumeWellReset_n(resumeWellReset_n),
    .smbClkIn(sclOut), .smbDataIn(sdaLine), .smbDataOut(smbDataOut), .smbDataOe(smbDataOe), .sysState(sysState),
    .statusClear(statusClear), .status(status), .action(action), .resetCtrlData(resetCtrlData),
    .slaveCommand(slaveCommand), .dataMessage0(dataMessage0), .dataMessage1(dataMessage1),
    .heartbeatDisabled(heartbeatDisabled));
  sswcd_master_model sswcd_master_model_inst (.clk(clk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaOut(sdaOut));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    seenAct <= clrAct ? '0 : (seenAct | action);
    cyc++;
    if (cyc == 60000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [7:0] addr = 8'h88);
    logic [2:0] acks;
    clrAct <= 1'b1;
    wt(1);
    clrAct <= 1'b0;
    sswcd_master_model_inst.frame(addr, idx, val, acks);
    chk(8'(acks), addr[0] ? 8'h00 : 8'h07);
  endtask
  task automatic clr();
    statusClear <= 3'h7;
    wt(1);
    statusClear <= 3'h0;
    wt(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    wt(12);
    rst_n <= 1'b1;
    resumeWellReset_n <= 1'b1;
    wt(4);
    sysState <= 5'h08;
    wr(8'h00, 8'h01);
    chk(8'(seenAct), 8'h10);
    chk(8'(status), 8'h04);
    clr();
    chk(8'(status), 8'h00);
    sysState <= 5'h10;
    wr(8'h00, 8'h01);
    chk(8'(seenAct), 8'h08);
    chk(8'(status), 8'h04);
    wr(8'h00, 8'h02);
    chk(8'(seenAct), 8'h04);
    chk(8'(status), 8'h06);
    clr();
    wr(8'h00, 8'h03);
    chk(8'(seenAct), 8'h01);
    chk(resetCtrlData, 8'h06);
    sysState <= 5'h08;
    wr(8'h00, 8'h03);
    chk(8'(seenAct), 8'h00);
    for (int i = 0; i < 5; i++) begin
      sysState <= st[i];
      wr(8'h00, 8'h04);
      chk(8'(seenAct), {7'h00, ok[i]});
      chk(resetCtrlData, 8'h0E);
    end
    sysState <= 5'h10;
    wr(8'h00, 8'h08);
    chk(8'(status), 8'h01);
    clr();
    sysState <= 5'h08;
    wr(8'h00, 8'h08);
    chk(8'(status), 8'h00);
    wr(8'h00, 8'h06);
    chk(8'(seenAct), 8'h02);
    foreach (st[i]) begin
      wr(8'h00, i == 0 ? 8'h00 : (i == 1 ? 8'h07 : (i == 2 ? 8'h09 : 8'hFF)));
      chk(8'(seenAct), 8'h00);
      chk(8'(status), 8'h00);
    end
    foreach (st[i]) begin
      wr(i == 0 ? 8'h01 : (i == 1 ? 8'h06 : (i == 2 ? 8'h08 : 8'hFF)), 8'h02);
      chk(8'(seenAct), 8'h00);
      chk(slaveCommand, 8'hFF);
    end
    wr(8'h04, 8'h5A);
    wr(8'h05, 8'h3C);
    chk(dataMessage0, 8'h5A);
    chk(dataMessage1, 8'h3C);
    wr(8'h04, 8'hC3);
    chk(dataMessage0, 8'hC3);
    chk(dataMessage1, 8'h3C);
    wr(8'h04, 8'h11, 8'h89);
    chk(dataMessage0, 8'hC3);
    wr(8'h00, 8'h05);
    chk(8'(heartbeatDisabled), 8'h01);
    rst_n <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
    wt(4);
    wr(8'h00, 8'h06);
    chk(8'(heartbeatDisabled), 8'h01);
    resumeWellReset_n <= 1'b0;
    wt(3);
    resumeWellReset_n <= 1'b1;
    wt(2);
    chk(8'(heartbeatDisabled), 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire

/* verif/sswcd_master_model.sv */
// management controller model acting as bus master
`timescale 1ns/1ps
`default_nettype none
module sswcd_master_model (
  input wire logic clk,
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaOut
);
  // ----------------------------------------------------------------
  // bit and frame tasks, clock idles high between frames
  // ----------------------------------------------------------------
  initial begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put_bit(input logic b, output logic seen);
    sclOut <= 1'b0;
    wt(2);
    sdaOut <= b;
    wt(2);
    sclOut <= 1'b1;
    wt(3);
    seen = sdaLine;
    wt(1);
  endtask
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic frame(input logic [7:0] addr, input logic [7:0] idx, input logic [7:0] val, output logic [2:0] acks);
    sdaOut <= 1'b1;
    sclOut <= 1'b1;
    wt(4);
    sdaOut <= 1'b0;
    wt(4);
    put_byte(addr, acks[2]);
    put_byte(idx, acks[1]);
    put_byte(val, acks[0]);
    sclOut <= 1'b0;
    wt(2);
    sdaOut <= 1'b0;
    wt(2);
    sclOut <= 1'b1;
    wt(4);
    sdaOut <= 1'b1;
    wt(4);
  endtask
endmodule
`default_nettype wire

/* verif/sswcd_top_assertions.sv */
// assertion checker for the slave write command decoder
`timescale 1ns/1ps
`default_nettype none
module sswcd_checker
  import sswcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resumeWellReset_n,
  input wire sswcd_sys_state_t sysState,
  input wire sswcd_status_t status,
  input wire sswcd_action_t action,
  input wire logic [7:0] resetCtrlData,
  input wire logic [7:0] slaveCommand,
  input wire logic heartbeatDisabled
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_WAKE: assert property (action.wakeSystem |->
    !$past(sysState.inS0) && status.smbusWakeStatus && slaveCommand == CMD_WAKE_OR_SMI) else $error("bad wake");
  AST_SMI: assert property (action.systemMgmtInterrupt |->
    $past(sysState.inS0) && status.smbusWakeStatus) else $error("bad interrupt");
  AST_PDOWN: assert property (action.powerdown |->
    status.powerButtonOverrideStatus && slaveCommand == CMD_POWERDOWN ##1 !action.powerdown) else $error("bad powerdown");
  AST_RST3: assert property (action.resetCtrlWrite && resetCtrlData == RSTC_NO_CYCLE |->
    $past(sysState.inS0) && slaveCommand == CMD_RESET_NO_CYCLE) else $error("bad reset without cycle");
  AST_RST4: assert property (action.resetCtrlWrite && resetCtrlData != RSTC_NO_CYCLE |->
    resetCtrlData == RSTC_WITH_CYCLE && slaveCommand == CMD_RESET_WITH_CYCLE && $past(sysState.inS0 ||
    sysState.sleepEnginePowered || sysState.sleepEnginePowerGated ||
    (sysState.sleepEngineOff && sysState.gracefulSleepEntry))) else $error("bad reset with cycle");
  AST_WDOG: assert property ($rose(action.watchdogReload) |->
    slaveCommand == CMD_WATCHDOG_RELOAD ##1 !action.watchdogReload) else $error("bad reload");
  AST_MSG_OFF: assert property ($rose(heartbeatDisabled) |-> slaveCommand == CMD_DISABLE_MESSAGES)
    else $error("messages off without command");
  AST_MSG_STAY: assert property (heartbeatDisabled |=> heartbeatDisabled || !resumeWellReset_n)
    else $error("messages re-enabled");
  AST_LINK: assert property ($rose(status.linkSlaveSmiStatus) |->
    $past(sysState.inS0) && slaveCommand == CMD_LINK_SLAVE_SMI) else $error("bad link status");
  AST_NONE: assert property (action != '0 |-> slaveCommand inside {[8'h01:8'h06]})
    else $error("action from reserved command");
  cover property (action.wakeSystem);
  cover property (action.resetCtrlWrite && resetCtrlData == RSTC_WITH_CYCLE);
  cover property ($rose(heartbeatDisabled));
endmodule

bind sswcd_top sswcd_checker sswcd_checker_inst (.clk(clk), .rst_n(rst_n), .resumeWellReset_n(resumeWellReset_n),
  .sysState(sysState), .status(status), .action(action), .resetCtrlData(resetCtrlData),
  .slaveCommand(slaveCommand), .heartbeatDisabled(heartbeatDisabled));
`default_nettype wire
